// file: verilog/jid_decoder.sv
// jid_decoder.sv: test-port instruction register, decoder and data register selection
// assumes: tap state levels come from the tap controller on core_clk_i; tck, tdi and
// assumes: pins arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - sample code captures pins, preloads pattern
// - extest drives boundary pattern, captures inputs
// - all-ones selects one-bit bypass stage
// - usercode shifts out 32-bit user register
// - idcode active at power-up and reset
// - highz selects bypass, tristates all pins
// - clamp selects bypass, holds boundary levels
// - bus-hold and pull-ups override high impedance
// - reconfig code pulses internal reconfiguration request
// - cfg-io interrupts config, loads io shift register
// - two codes switch configuration clock source
// - idle/engage codes control active configuration controller
// - boot code shifts 22-bit boot address
// - factory code unlocks, erases config and key
// - key load feeds 512-bit chain, no tdo
// - key clear held ten tck clears validity
// - bypass, idcode, sample safe during configuration
// - security variant locks codes until factory
// - idcode still selected at tap reset
`timescale 1ns/1ps
`include "jid_params.svh"
module jid_decoder
    import jid_pkg::*;
#(
    parameter logic SECURE_VARIANT = 1'b0,          // one for the security variant
    parameter logic [31:0] IDENT_VALUE = 32'h0000_0001  // arbitrary identification value
) (
    input  wire logic                   core_clk_i,     // core clock, 100 mhz
    input  wire logic                   rst_b_i,        // synchronous reset, active low
    input  wire logic                   tck_i,          // test clock pin
    input  wire logic                   tdi_i,          // serial data in pin
    input  wire logic                   tap_reset_i,    // tap in reset state, level
    input  wire logic                   capture_ir_i,   // tap in capture-ir, level
    input  wire logic                   shift_ir_i,     // tap in shift-ir, level
    input  wire logic                   update_ir_i,    // tap in update-ir, level
    input  wire logic                   capture_dr_i,   // tap in capture-dr, level
    input  wire logic                   shift_dr_i,     // tap in shift-dr, level
    input  wire logic                   update_dr_i,    // tap in update-dr, level
    input  wire logic                   configuring_i,  // configuration in progress
    input  wire logic                   config_status_pin_i, // status pin level
    input  wire logic                   active_scheme_i,    // active configuration scheme
    input  wire logic                   bus_hold_en_i,  // bus-hold or pull-up enabled
    input  wire logic [31:0]            usercode_i,     // user code value
    output logic                        tdo_o,          // serial data out
    output logic                        tdo_oe_b_o,     // tdo enable, low drives
    output jid_pkg::jid_dr_type         dr_select_o,    // data register on path
    output jid_pkg::jid_pin_type        pin_mode_o,     // boundary pin mode
    output logic                        pin_keeper_o,   // keeper overrides highz
    output logic                        bound_capture_o,// pulse: capture boundary cells
    output logic                        bound_shift_o,  // pulse: shift boundary cells
    output logic                        bound_update_o, // pulse: update boundary cells
    output logic                        reconfig_req_o, // pulse: internal reconfiguration
    output logic                        io_cfg_load_o,  // io shift register loading
    output logic                        cfg_interrupt_o,// configuration interrupted
    output logic                        user_clk_sel_o, // config clock from user pin
    output logic                        active_idle_o,  // active controller idled
    output logic [21:0]                 boot_addr_o,    // boot address to flash ctrl
    output logic                        boot_addr_vld_o,// pulse: new boot address
    output logic                        factory_erase_o,// pulse: erase config and key
    output logic                        unlocked_o,     // security gating released
    output logic                        key_shift_o,    // pulse: key chain shift
    output logic                        key_bit_o,      // bit shifted into key chain
    output logic                        key_valid_clr_o // pulse: clear key validity
);
    // ==========================================================
    // synchronised test clock and data
    logic tck_lvl;                      // synchronised tck
    logic tck_rise;                     // tck rising edge
    logic tck_fall;                     // tck falling edge
    logic tdi_lvl;                      // synchronised tdi
    logic tdi_rise_unused;              // not used for tdi
    logic tdi_fall_unused;              // not used for tdi

    jid_link_sync u_tck_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (tck_i),
        .level_o    (tck_lvl),
        .rise_o     (tck_rise),
        .fall_o     (tck_fall)
    );

    jid_link_sync u_tdi_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (tdi_i),
        .level_o    (tdi_lvl),
        .rise_o     (tdi_rise_unused),
        .fall_o     (tdi_fall_unused)
    );

    // status pin crosses into the core clock domain
    logic stat_lvl;                     // synchronised status pin
    jid_link_sync u_stat_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (config_status_pin_i),
        .level_o    (stat_lvl),
        .rise_o     (),
        .fall_o     ()
    );

    // ==========================================================
    // state registers
    logic [`JID_IR_W-1:0]   ir_shift_reg;   // instruction shift stage
    logic [`JID_IR_W-1:0]   ir_reg;         // active instruction
    logic                   bypass_reg;     // one-bit bypass stage
    logic [31:0]            id_shift_reg;   // ident / usercode shift stage
    logic [`JID_BOOT_W-1:0] boot_shift_reg; // boot address shift stage
    logic                   unlocked_reg;   // factory code seen
    logic                   interrupted_reg;// configuration interrupted
    logic [3:0]             keyclr_cnt_reg; // tck count of key clear
    logic                   keyclr_done_reg;// clear already issued
    logic                   serial_out;     // selected serial bit

    // ==========================================================
    // decode: gate codes by configuration and security state
    logic [`JID_IR_W-1:0] ir_eff;           // instruction after gating
    logic                 known;            // code in supported set
    logic                 safe_cfg;         // allowed mid-configuration
    logic                 pre_unlock;       // allowed before factory

    always_comb begin
        known = 1'b1;
        case (ir_reg)
            `JID_SAMPLE_CODE, `JID_EXTEST_CODE, `JID_BYPASS_CODE, `JID_USERCODE_CODE,
            `JID_IDCODE_CODE, `JID_HIGHZ_CODE, `JID_CLAMP_CODE, `JID_RECONF_CODE,
            `JID_CFG_IO_CODE, `JID_USRCLK_CODE, `JID_OSCCLK_CODE, `JID_IDLE_CODE,
            `JID_ENGAGE_CODE: known = 1'b1;
            `JID_BOOT_CODE: known = !SECURE_VARIANT;
            `JID_FACTORY_CODE, `JID_KEYLOAD_CODE, `JID_KEYCLR_CODE: known = SECURE_VARIANT;
            default: known = 1'b0;
        endcase
        // bypass, idcode and sample never disturb configuration
        safe_cfg = (ir_reg == `JID_BYPASS_CODE) || (ir_reg == `JID_IDCODE_CODE) ||
                   (ir_reg == `JID_SAMPLE_CODE) || (ir_reg == `JID_CFG_IO_CODE) ||
                   (ir_reg == `JID_IDLE_CODE && active_scheme_i) ||
                   (ir_reg == `JID_FACTORY_CODE);
        // only the mandatory set and factory before unlock
        pre_unlock = (ir_reg == `JID_BYPASS_CODE) || (ir_reg == `JID_SAMPLE_CODE) ||
                     (ir_reg == `JID_EXTEST_CODE) || (ir_reg == `JID_FACTORY_CODE);
        ir_eff = ir_reg;
        if (!known) begin
            ir_eff = `JID_BYPASS_CODE;
        end else if (SECURE_VARIANT && !unlocked_reg && !pre_unlock &&
                     !(ir_reg == `JID_IDCODE_CODE && tap_reset_i)) begin
            ir_eff = `JID_BYPASS_CODE;
        end else if (configuring_i && !interrupted_reg && !safe_cfg) begin
            ir_eff = `JID_BYPASS_CODE;
        end
    end

    // ==========================================================
    // instruction register: capture, shift, update, reset to idcode
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ir_shift_reg <= `JID_IR_CAPTURE;
            ir_reg       <= `JID_IDCODE_CODE;
        end else if (tap_reset_i) begin
            ir_reg       <= `JID_IDCODE_CODE;
        end else if (tck_rise) begin
            if (capture_ir_i) begin
                ir_shift_reg <= `JID_IR_CAPTURE;
            end else if (shift_ir_i) begin
                ir_shift_reg <= {tdi_lvl, ir_shift_reg[`JID_IR_W-1:1]};
            end
        end else if (tck_fall && update_ir_i) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // ==========================================================
    // data registers: bypass, ident/usercode, boot address
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            bypass_reg     <= 1'b0;
            id_shift_reg   <= 32'h0000_0000;
            boot_shift_reg <= '0;
        end else if (tck_rise) begin
            if (capture_dr_i) begin
                bypass_reg <= 1'b0;
                if (ir_eff == `JID_USERCODE_CODE) begin
                    id_shift_reg <= usercode_i;
                end else begin
                    id_shift_reg <= IDENT_VALUE;
                end
            end else if (shift_dr_i) begin
                bypass_reg     <= tdi_lvl;
                id_shift_reg   <= {tdi_lvl, id_shift_reg[31:1]};
                boot_shift_reg <= {tdi_lvl, boot_shift_reg[`JID_BOOT_W-1:1]};
            end
        end
    end

    // ==========================================================
    // data register selection and serial output mux
    jid_dr_type dr_sel;                 // combinational selection
    always_comb begin
        case (ir_eff)
            `JID_SAMPLE_CODE, `JID_EXTEST_CODE: dr_sel = JID_DR_BOUND;
            `JID_IDCODE_CODE:   dr_sel = JID_DR_IDENT;
            `JID_USERCODE_CODE: dr_sel = JID_DR_USER;
            `JID_BOOT_CODE:     dr_sel = JID_DR_BOOT;
            `JID_KEYLOAD_CODE:  dr_sel = JID_DR_KEY;
            default:            dr_sel = JID_DR_BYPASS;
        endcase
        case (dr_sel)
            JID_DR_IDENT, JID_DR_USER: serial_out = id_shift_reg[0];
            JID_DR_BOOT:               serial_out = boot_shift_reg[0];
            JID_DR_KEY:                serial_out = 1'b0;
            default:                   serial_out = bypass_reg;
        endcase
    end

    // ==========================================================
    // tdo changes on falling tck, driven only while shifting
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tdo_o      <= 1'b0;
            tdo_oe_b_o <= 1'b1;
        end else if (tck_fall) begin
            tdo_o      <= shift_ir_i ? ir_shift_reg[0] : serial_out;
            tdo_oe_b_o <= !(shift_ir_i || (shift_dr_i && dr_sel != JID_DR_KEY));
        end
    end

    // ==========================================================
    // pin mode and boundary strobes
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            dr_select_o     <= JID_DR_IDENT;
            pin_mode_o      <= JID_PIN_NORMAL;
            pin_keeper_o    <= 1'b0;
            bound_capture_o <= 1'b0;
            bound_shift_o   <= 1'b0;
            bound_update_o  <= 1'b0;
        end else begin
            dr_select_o <= dr_sel;
            case (ir_eff)
                `JID_EXTEST_CODE: pin_mode_o <= JID_PIN_DRIVE;
                `JID_HIGHZ_CODE:  pin_mode_o <= JID_PIN_HIGHZ;
                `JID_CLAMP_CODE:  pin_mode_o <= JID_PIN_CLAMP;
                default:          pin_mode_o <= JID_PIN_NORMAL;
            endcase
            // keepers win over released pins
            pin_keeper_o    <= bus_hold_en_i && (ir_eff == `JID_EXTEST_CODE ||
                               ir_eff == `JID_HIGHZ_CODE || ir_eff == `JID_CLAMP_CODE);
            bound_capture_o <= tck_rise && capture_dr_i && dr_sel == JID_DR_BOUND;
            bound_shift_o   <= tck_rise && shift_dr_i && dr_sel == JID_DR_BOUND;
            bound_update_o  <= tck_fall && update_dr_i && dr_sel == JID_DR_BOUND;
        end
    end

    // ==========================================================
    // configuration control: reconfig, io load, clock source, idle
    logic ir_upd;                        // instruction update strobe
    assign ir_upd = tck_fall && update_ir_i;
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            reconfig_req_o  <= 1'b0;
            io_cfg_load_o   <= 1'b0;
            interrupted_reg <= 1'b0;
            user_clk_sel_o  <= 1'b0;
            active_idle_o   <= 1'b0;
        end else begin
            reconfig_req_o <= tck_rise && ir_eff == `JID_RECONF_CODE && update_dr_i;
            // io load only once status pin has risen
            io_cfg_load_o  <= ir_eff == `JID_CFG_IO_CODE && stat_lvl;
            if (ir_eff == `JID_RECONF_CODE && tck_rise && update_dr_i) begin
                interrupted_reg <= 1'b0;
                active_idle_o   <= 1'b0;
            end else if (!ir_upd) begin
                if (ir_eff == `JID_CFG_IO_CODE && stat_lvl) begin
                    interrupted_reg <= 1'b1;
                end
                if (ir_eff == `JID_IDLE_CODE) begin
                    interrupted_reg <= 1'b1;
                    active_idle_o   <= 1'b1;
                end else if (ir_eff == `JID_ENGAGE_CODE) begin
                    active_idle_o   <= 1'b0;
                end
            end
            if (ir_eff == `JID_USRCLK_CODE) begin
                user_clk_sel_o <= 1'b1;
            end else if (ir_eff == `JID_OSCCLK_CODE) begin
                user_clk_sel_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // boot address delivery on update-dr
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            boot_addr_o     <= '0;
            boot_addr_vld_o <= 1'b0;
        end else begin
            boot_addr_vld_o <= tck_fall && update_dr_i && ir_eff == `JID_BOOT_CODE;
            if (tck_fall && update_dr_i && ir_eff == `JID_BOOT_CODE) begin
                boot_addr_o <= boot_shift_reg;
            end
        end
    end

    // ==========================================================
    // security: factory unlock, key chain, key validity clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            unlocked_reg    <= !SECURE_VARIANT;
            factory_erase_o <= 1'b0;
            key_shift_o     <= 1'b0;
            key_bit_o       <= 1'b0;
            key_valid_clr_o <= 1'b0;
            keyclr_cnt_reg  <= 4'd0;
            keyclr_done_reg <= 1'b0;
        end else begin
            // erase pulses once, on the instruction update
            factory_erase_o <= ir_upd && ir_shift_reg == `JID_FACTORY_CODE && SECURE_VARIANT;
            if (ir_upd && ir_shift_reg == `JID_FACTORY_CODE && SECURE_VARIANT) begin
                unlocked_reg <= 1'b1;
            end
            key_shift_o <= tck_rise && shift_dr_i && ir_eff == `JID_KEYLOAD_CODE;
            key_bit_o   <= tdi_lvl;
            // count tck cycles while key clear stays active
            key_valid_clr_o <= 1'b0;
            if (ir_eff != `JID_KEYCLR_CODE) begin
                keyclr_cnt_reg  <= 4'd0;
                keyclr_done_reg <= 1'b0;
            end else if (tck_rise && !keyclr_done_reg) begin
                if (keyclr_cnt_reg == `JID_KEYCLR_TCK - 4'd1) begin
                    key_valid_clr_o <= 1'b1;
                    keyclr_done_reg <= 1'b1;
                end else begin
                    keyclr_cnt_reg <= keyclr_cnt_reg + 4'd1;
                end
            end
        end
    end

    assign unlocked_o      = unlocked_reg;
    assign cfg_interrupt_o = interrupted_reg;
endmodule

// file: include/jid_params.svh
// jid_params.svh: instruction codes, chain lengths and timing counts for the test-port decoder
// assumes: included by the decoder and bench top modules by bare name
`ifndef JID_PARAMS_SVH
`define JID_PARAMS_SVH

// ==========================================================
// instruction register geometry
`define JID_IR_W            10
`define JID_IR_CAPTURE      10'h001

// ==========================================================
// instruction codes
`define JID_SAMPLE_CODE     10'h005
`define JID_EXTEST_CODE     10'h00f
`define JID_BYPASS_CODE     10'h3ff
`define JID_USERCODE_CODE   10'h007
`define JID_IDCODE_CODE     10'h006
`define JID_HIGHZ_CODE      10'h00b
`define JID_CLAMP_CODE      10'h00a
`define JID_RECONF_CODE     10'h001
`define JID_CFG_IO_CODE     10'h00d
`define JID_USRCLK_CODE     10'h1ee
`define JID_OSCCLK_CODE     10'h2ee
`define JID_IDLE_CODE       10'h2d0
`define JID_ENGAGE_CODE     10'h2b0
`define JID_BOOT_CODE       10'h270
`define JID_FACTORY_CODE    10'h281
`define JID_KEYLOAD_CODE    10'h1ad
`define JID_KEYCLR_CODE     10'h029

// ==========================================================
// data register lengths
`define JID_USER_W          32
`define JID_BOOT_W          22
`define JID_KEY_W           512

// ==========================================================
// timing: key clear must be held this many test clock cycles
`define JID_KEYCLR_TCK      4'd10

`endif

// file: include/jid_pkg.sv
// jid_pkg.sv: types shared by the test-port decoder files
// assumes: compiled before the design modules
package jid_pkg;
    // ==========================================================
    // data register selected onto the serial path
    typedef enum logic [5:0] {
        JID_DR_BYPASS = 6'h01,
        JID_DR_BOUND  = 6'h02,
        JID_DR_IDENT  = 6'h04,
        JID_DR_USER   = 6'h08,
        JID_DR_BOOT   = 6'h10,
        JID_DR_KEY    = 6'h20
    } jid_dr_type;

    // ==========================================================
    // pin mode requested of the boundary cells
    typedef enum logic [3:0] {
        JID_PIN_NORMAL = 4'h1,
        JID_PIN_DRIVE  = 4'h2,
        JID_PIN_HIGHZ  = 4'h4,
        JID_PIN_CLAMP  = 4'h8
    } jid_pin_type;
endpackage

// file: verilog/jid_link_sync.sv
// jid_link_sync.sv: two-flop synchroniser with rising and falling edge detection
// assumes: input comes from outside the core clock domain
`timescale 1ns/1ps
module jid_link_sync (
    input  wire logic core_clk_i,   // core clock
    input  wire logic rst_b_i,      // synchronous reset, active low
    input  wire logic async_i,      // raw pin level
    output logic      level_o,      // synchronised level
    output logic      rise_o,       // one-cycle pulse on rising edge
    output logic      fall_o        // one-cycle pulse on falling edge
);
    logic meta_reg;                 // first stage, read only by second
    logic sync_reg;                 // second stage
    logic last_reg;                 // previous synchronised value

    // ==========================================================
    // synchroniser chain
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_o = sync_reg;
    assign rise_o  = sync_reg & ~last_reg;
    assign fall_o  = ~sync_reg & last_reg;
endmodule

// file: tb/jid_decoder_sva.sv
// jid_decoder_sva.sv: port checks on the test-port decoder
// assumes: bound into every jid_decoder, sees its ports only
`timescale 1ns/1ps
module jid_decoder_chk
    import jid_pkg::*;
(
    input wire logic core_clk_i, rst_b_i, tap_reset_i, bus_hold_en_i, tdo_oe_b_o, pin_keeper_o,
    input wire logic reconfig_req_o, boot_addr_vld_o, factory_erase_o, unlocked_o,
    input wire jid_pkg::jid_dr_type  dr_select_o,
    input wire jid_pkg::jid_pin_type pin_mode_o
);
    // ==========================================================
    // one clock domain, reset disables all
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence tap_held_s; tap_reset_i [*3]; endsequence
    sequence keep_req_s; (pin_mode_o == JID_PIN_HIGHZ && bus_hold_en_i) [*3]; endsequence
    chk_tap_ident: assert property (tap_held_s |-> dr_select_o == JID_DR_IDENT) else $error("no ident");
    chk_keeper_wins: assert property (keep_req_s |=> pin_keeper_o) else $error("keeper off");
    chk_highz_path: assert property (pin_mode_o == JID_PIN_HIGHZ |-> dr_select_o == JID_DR_BYPASS) else $error("highz");
    chk_clamp_path: assert property (pin_mode_o == JID_PIN_CLAMP |-> dr_select_o == JID_DR_BYPASS) else $error("clamp");
    chk_drive_path: assert property (pin_mode_o == JID_PIN_DRIVE |-> dr_select_o == JID_DR_BOUND) else $error("drive");
    chk_key_quiet: assert property (dr_select_o == JID_DR_KEY |-> tdo_oe_b_o) else $error("key on tdo");
    chk_reconf_pulse: assert property (reconfig_req_o |=> !reconfig_req_o) else $error("reconf held");
    chk_boot_pulse: assert property ($rose(boot_addr_vld_o) |=> $fell(boot_addr_vld_o)) else $error("boot vld");
    chk_erase_unlock: assert property (factory_erase_o |=> unlocked_o) else $error("not unlocked");
endmodule
bind jid_decoder jid_decoder_chk jid_decoder_chk_i (.*);

// file: tb/jid_tester.sv
// jid_tester.sv: tester model driving test clock, data and tap levels
// assumes: tck stands low between frames, tdi pulled up when released
`timescale 1ns/1ps
module jid_tester (
    input  wire logic clk_i,  // core clock, phases each frame
    input  wire logic tdo_i,  // serial data from decoder
    output logic      tck_o,  // test clock
    output logic      tdi_o,  // serial data
    output logic [6:0] st_o   // reset,cir,sir,uir,cdr,sdr,udr
);
    initial {tck_o, tdi_o, st_o} = 9'h080;
    // one tck period; tdo taken before the rise
    task automatic tick(input logic [6:0] st, input logic d, output logic q);
        @(posedge clk_i);
        st_o <= st;
        tdi_o <= d;
        q = tdo_i;
        #62.5 tck_o = 1'b1;
        #62.5 tck_o = 1'b0;
        #50 tdi_o = 1'b1;
    endtask
    // whole instruction scan, lsb first
    task automatic ir_load(input logic [9:0] c);
        logic q;
        tick(7'h20, 1'b1, q);
        for (int i = 0; i < 10; i++) tick(7'h10, c[i], q);
        tick(7'h08, 1'b1, q);
        @(posedge clk_i) st_o <= 7'h00;
        #100;
    endtask
    // data scan of n bits with update
    task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        tick(7'h04, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            tick(7'h02, din[i], q);
            dout[i] = q;
        end
        tick(7'h01, 1'b1, q);
        @(posedge clk_i) st_o <= 7'h00;
        #100;
    endtask
endmodule

// file: tb/jtag_instruction_decoder_tb_top.sv
// bench top: decoder, tester model, scenarios
// assumes: tester model and checker compiled first
`timescale 1ns/1ps
`include "jid_params.svh"
module jtag_instruction_decoder_tb_top;
    import jid_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, cfg = 1'b0, stat = 1'b0, act = 1'b0, hold = 1'b0;
    logic tck, tdi, tdo, oe_b, keep, rcf, intr, usel, aidle, unl;
    logic [6:0] st;
    logic [21:0] boot;
    logic [31:0] ucode = 32'hc3a5_0f96;
    jid_dr_type dr;
    jid_pin_type pm;
    int n_mismatch = 0, cmp_count = 0, n_rcf = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (rcf === 1'b1) n_rcf <= n_rcf + 1;
    jid_decoder jid_decoder_i (.core_clk_i(clk), .rst_b_i(rst_b), .tck_i(tck), .tdi_i(tdi), .tap_reset_i(st[6]),
        .capture_ir_i(st[5]), .shift_ir_i(st[4]), .update_ir_i(st[3]), .capture_dr_i(st[2]), .shift_dr_i(st[1]),
        .update_dr_i(st[0]), .configuring_i(cfg), .config_status_pin_i(stat), .active_scheme_i(act),
        .bus_hold_en_i(hold), .usercode_i(ucode), .tdo_o(tdo), .tdo_oe_b_o(oe_b), .dr_select_o(dr), .pin_mode_o(pm),
        .pin_keeper_o(keep), .bound_capture_o(), .bound_shift_o(), .bound_update_o(), .reconfig_req_o(rcf),
        .io_cfg_load_o(), .cfg_interrupt_o(intr), .user_clk_sel_o(usel), .active_idle_o(aidle), .boot_addr_o(boot),
        .boot_addr_vld_o(), .factory_erase_o(), .unlocked_o(unl), .key_shift_o(), .key_bit_o(), .key_valid_clr_o());
    jid_tester jid_tester_i (.clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi), .st_o(st));
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic ld(input logic [9:0] c, input jid_dr_type d, input jid_pin_type p);
        jid_tester_i.ir_load(c);
        chk(dr === d && pm === p, "path or pin mode");
    endtask
    task automatic sc_decode;
        logic [31:0] got;
        ld(`JID_SAMPLE_CODE, JID_DR_BOUND, JID_PIN_NORMAL);
        ld(`JID_EXTEST_CODE, JID_DR_BOUND, JID_PIN_DRIVE);
        ld(`JID_HIGHZ_CODE, JID_DR_BYPASS, JID_PIN_HIGHZ);
        @(posedge clk) hold <= 1'b1;
        repeat (5) @(posedge clk);
        chk(keep === 1'b1, "keeper off");
        hold <= 1'b0;
        ld(`JID_CLAMP_CODE, JID_DR_BYPASS, JID_PIN_CLAMP);
        ld(`JID_KEYLOAD_CODE, JID_DR_BYPASS, JID_PIN_NORMAL);
        ld(10'h155, JID_DR_BYPASS, JID_PIN_NORMAL);
        ld(`JID_BOOT_CODE, JID_DR_BOOT, JID_PIN_NORMAL);
        jid_tester_i.dr_scan(22, 32'h0029_a5c3, got);
        chk(boot === 22'h29a5c3, "boot address");
    endtask
    task automatic sc_scan;
        logic [31:0] got;
        ld(`JID_USERCODE_CODE, JID_DR_USER, JID_PIN_NORMAL);
        jid_tester_i.dr_scan(32, 32'h0, got);
        chk(got === ucode, "user code");
        ld(`JID_BYPASS_CODE, JID_DR_BYPASS, JID_PIN_NORMAL);
        jid_tester_i.dr_scan(8, 32'h96, got);
        chk(got[7:0] === 8'h2c, "bypass delay");
        jid_tester_i.tick(7'h40, 1'b1, got[0]);
        #100;
        chk(dr === JID_DR_IDENT, "tap reset");
    endtask
    task automatic sc_cfg;
        logic [31:0] got;
        @(posedge clk) cfg <= 1'b1;
        ld(`JID_SAMPLE_CODE, JID_DR_BOUND, JID_PIN_NORMAL);
        ld(`JID_EXTEST_CODE, JID_DR_BYPASS, JID_PIN_NORMAL);
        @(posedge clk) stat <= 1'b1;
        jid_tester_i.ir_load(`JID_CFG_IO_CODE);
        chk(intr === 1'b1, "not interrupted");
        ld(`JID_EXTEST_CODE, JID_DR_BOUND, JID_PIN_DRIVE);
        jid_tester_i.ir_load(`JID_RECONF_CODE);
        jid_tester_i.dr_scan(1, 32'h0, got);
        chk(n_rcf === 1 && intr === 1'b0, "reconfig pulse");
        @(posedge clk) cfg <= 1'b0;
    endtask
    task automatic sc_ctrl;
        jid_tester_i.ir_load(`JID_USRCLK_CODE);
        chk(usel === 1'b1, "user clock");
        jid_tester_i.ir_load(`JID_OSCCLK_CODE);
        chk(usel === 1'b0, "oscillator");
        @(posedge clk) act <= 1'b1;
        jid_tester_i.ir_load(`JID_IDLE_CODE);
        chk(aidle === 1'b1, "not idled");
        jid_tester_i.ir_load(`JID_ENGAGE_CODE);
        chk(aidle === 1'b0, "not engaged");
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #900000;
        n_mismatch++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk(dr === JID_DR_IDENT && pm === JID_PIN_NORMAL && oe_b === 1'b1 && unl === 1'b1, "reset");
        sc_decode;
        sc_scan;
        sc_cfg;
        sc_ctrl;
        summarize;
    end
endmodule
